// >>> logic/stpdrv_pkg.sv
// Shared constants and types of the stepper translator and current chopper
`default_nettype none
package stpdrv_pkg;

    // ==========================================
    // Time base
    localparam int CLK_MHZ = 250;
    localparam int CLK_PERIOD_NS = 4;
    localparam int STEP_MIN_PULSE_NS = 1000;
    localparam int BLANK_TIME_NS = 1000;
    localparam int BLANK_CYCLES = (BLANK_TIME_NS / CLK_PERIOD_NS) > 0 ? (BLANK_TIME_NS / CLK_PERIOD_NS) : 1;
    localparam int OFF_DEFAULT_US = 30;
    localparam int OFF_DEFAULT_CYCLES = OFF_DEFAULT_US * CLK_MHZ;
    localparam int OFF_FAST_NUM = 5;
    localparam int OFF_FAST_SHIFT = 4;
    localparam int OFF_CYC_W = 24;

    // ==========================================
    // Translator table
    localparam logic [2:0] HOME_IDX = 3'h1;
    localparam logic [7:0] LVL_FULL = 8'hFF;
    localparam logic [7:0] LVL_SIN45 = 8'hB4;
    localparam logic [7:0] LVL_ZERO = 8'h00;

    // ==========================================
    // Register map (AHB-Lite, byte addresses)
    localparam logic [7:0] REG_CFG_OFS = 8'h00;
    localparam logic [7:0] REG_STATUS_OFS = 8'h04;
    localparam logic [7:0] REG_LEVEL_OFS = 8'h08;
    localparam logic [15:0] CFG_OSC_UNITS_RST = 16'h001E;
    localparam int ST_IDX_LSB = 0;
    localparam int ST_DIR_BIT = 3;
    localparam int ST_HALF_BIT = 4;
    localparam int ST_DECAY1_BIT = 5;
    localparam int ST_DECAY2_BIT = 6;
    localparam int ST_OUT_OFF_BIT = 7;
    localparam int ST_FAULT_LSB = 8;
    localparam int LV_DAC1_LSB = 0;
    localparam int LV_POL1_BIT = 8;
    localparam int LV_DAC2_LSB = 16;
    localparam int LV_POL2_BIT = 24;

    typedef enum logic [3:0] {
        STPDRV_CH_IDLE = 4'b0001,
        STPDRV_CH_ON = 4'b0010,
        STPDRV_CH_FAST = 4'b0100,
        STPDRV_CH_SLOW = 4'b1000
    } stpdrv_ch_state_t;

endpackage : stpdrv_pkg
`default_nettype wire

// >>> logic/stpdrv_chopper.sv
// Fixed off-time current chopper for one full bridge
`timescale 1ns/1ps
`default_nettype none
module stpdrv_chopper
    import stpdrv_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic polarity_neg,
    input wire logic decay_mixed,
    input wire logic cmp_trip,
    input wire logic [OFF_CYC_W-1:0] off_cycles,
    input wire logic [OFF_CYC_W-1:0] fast_cycles,
    output logic src_a,
    output logic src_b,
    output logic snk_a,
    output logic snk_b,
    output logic chopping
);

    // ==========================================
    // State and counter
    stpdrv_ch_state_t st_q, st_d;
    logic [OFF_CYC_W-1:0] cnt_q, cnt_d;
    logic [3:0] gate_q, gate_d;

    wire logic [OFF_CYC_W-1:0] cnt_inc = cnt_q + 1'b1;
    wire logic blank_done = cnt_q >= OFF_CYC_W'(BLANK_CYCLES - 1);
    wire logic off_done = cnt_inc >= off_cycles;
    wire logic fast_done = cnt_inc >= fast_cycles;
    wire logic trip_seen = blank_done && cmp_trip;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_inc;
        case (st_q)
            STPDRV_CH_IDLE: begin
                cnt_d = '0;
                if (run) begin
                    st_d = STPDRV_CH_ON;
                end
            end
            STPDRV_CH_ON: begin
                if (!run) begin
                    st_d = STPDRV_CH_IDLE;
                    cnt_d = '0;
                end else if (trip_seen) begin
                    // Comparator ignored until blank_done
                    st_d = decay_mixed ? STPDRV_CH_FAST : STPDRV_CH_SLOW;
                    cnt_d = '0;
                end else if (blank_done) begin
                    cnt_d = cnt_q;
                end
            end
            STPDRV_CH_FAST: begin
                if (!run || off_done) begin
                    st_d = run ? STPDRV_CH_ON : STPDRV_CH_IDLE;
                    cnt_d = '0;
                end else if (fast_done) begin
                    st_d = STPDRV_CH_SLOW;
                end
            end
            STPDRV_CH_SLOW: begin
                if (!run || off_done) begin
                    st_d = run ? STPDRV_CH_ON : STPDRV_CH_IDLE;
                    cnt_d = '0;
                end
            end
            default: begin
                st_d = STPDRV_CH_IDLE;
                cnt_d = '0;
            end
        endcase
    end

    // Gate order {src_a, src_b, snk_a, snk_b}; diagonal pair set by polarity
    always_comb begin
        case (st_d)
            STPDRV_CH_ON: gate_d = polarity_neg ? 4'b0110 : 4'b1001;
            STPDRV_CH_SLOW: gate_d = polarity_neg ? 4'b0010 : 4'b0001;
            default: gate_d = 4'b0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_q <= STPDRV_CH_IDLE;
            cnt_q <= '0;
            gate_q <= 4'h0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            gate_q <= gate_d;
        end
    end

    assign src_a = gate_q[3];
    assign src_b = gate_q[2];
    assign snk_a = gate_q[1];
    assign snk_b = gate_q[0];
    assign chopping = (st_q == STPDRV_CH_FAST) || (st_q == STPDRV_CH_SLOW);

    // ==========================================
    // Checks
    property p_blank_hold;
        @(posedge core_clk) disable iff (sys_rst)
        (st_q == STPDRV_CH_ON && run && !blank_done) |=> (st_q == STPDRV_CH_ON);
    endproperty
    a_blank_hold: assert property (p_blank_hold) else $error("comparator acted inside blank time");

    property p_slow_src_only;
        @(posedge core_clk) disable iff (sys_rst)
        (st_q == STPDRV_CH_ON && run && trip_seen && !decay_mixed)
            |=> (!src_a && !src_b && (snk_a || snk_b));
    endproperty
    a_slow_src_only: assert property (p_slow_src_only) else $error("slow decay did not keep sink on");

    sequence s_mixed_trip;
        st_q == STPDRV_CH_ON && run && trip_seen && decay_mixed && fast_cycles > 1;
    endsequence
    property p_mixed_fast;
        @(posedge core_clk) disable iff (sys_rst)
        s_mixed_trip |=> (!src_a && !src_b && !snk_a && !snk_b && st_q == STPDRV_CH_FAST);
    endproperty
    a_mixed_fast: assert property (p_mixed_fast) else $error("mixed decay did not start fast");

    property p_off_length;
        @(posedge core_clk) disable iff (sys_rst)
        ($past(chopping) && !chopping && st_q == STPDRV_CH_ON && $past(run))
            |-> ($past(cnt_q) + 1'b1 >= $past(off_cycles));
    endproperty
    a_off_length: assert property (p_off_length) else $error("off time ended early");

endmodule : stpdrv_chopper
`default_nettype wire

// >>> logic/stpdrv_top.sv
// Step/direction translator with two bridge choppers and AHB-Lite status port
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Each rising step edge advances translator, updating both levels and polarities.
// - Step size select low gives full steps, high gives half steps.
// - Power-up or reset loads Home levels and sets both decays to mixed.
// - Level falling gives mixed decay; rising or equal gives slow decay.
// - Reset pin low holds Home, outputs off, step edges ignored.
// - Direction low clockwise, high counterclockwise; sampled only at step edge.
// - Conduction enables diagonal pair; comparator trip ends it.
// - Trip turns off source in slow decay, source and sink in mixed.
// - Off-time one-shot: 30 us if timing pin high, else resistance/825; code uses osc_units_q from CFG as microseconds.
// - Comparators ignored for about 1 us after each switching event; the chopper blanks only on entering STPDRV_CH_ON, not at a polarity change.
// - Level output scales reference to table percentage of max trip current.
// - Output disable high forces all bridge outputs off.
// - Translator keeps stepping while outputs are disabled.
// - Gate regulator monitor fault disables all bridge outputs.
// - Eight half-step positions at 45 degrees; Home is both +70.71 percent.
// - Mixed decay runs fast for 31.25 percent of off-time, then slow.
// - Overtemperature or undervoltage disables outputs; power-on undervoltage returns Home.
module stpdrv_top
    import stpdrv_pkg::*;
#(
    parameter int OFF_DEFAULT_CYC = OFF_DEFAULT_CYCLES
)(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic step_in,
    input wire logic dir_in,
    input wire logic step_size_select,
    input wire logic reset_pin_n,
    input wire logic out_disable,
    input wire logic off_time_timing_pin,
    input wire logic gate_regulator_monitor,
    input wire logic overtemp_fault,
    input wire logic undervolt_fault,
    input wire logic cmp_trip1,
    input wire logic cmp_trip2,
    output logic [7:0] level1,
    output logic pol1_neg,
    output logic [7:0] level2,
    output logic pol2_neg,
    output logic out1a_src,
    output logic out1b_src,
    output logic out1a_snk,
    output logic out1b_snk,
    output logic out2a_src,
    output logic out2b_src,
    output logic out2a_snk,
    output logic out2b_snk,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);

    // ==========================================
    // Table lookup: magnitude and sign of phase 1 at a half-step index
    function automatic logic [8:0] phase_lvl(input logic [2:0] idx);
        logic [7:0] mag;
        mag = idx[0] ? LVL_SIN45 : (idx[1] ? LVL_ZERO : LVL_FULL);
        return {(idx == 3'h3) || (idx == 3'h4) || (idx == 3'h5), mag};
    endfunction

    // ==========================================
    // Input synchronisers
    logic [4:0] sync1_q, sync2_q;
    logic step_prev_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync1_q <= 5'h08;
            sync2_q <= 5'h08;
            step_prev_q <= 1'b0;
        end else begin
            sync1_q <= {out_disable, reset_pin_n, step_size_select, dir_in, step_in};
            sync2_q <= sync1_q;
            step_prev_q <= sync2_q[0];
        end
    end
    wire logic step_s = sync2_q[0];
    wire logic dir_s = sync2_q[1];
    wire logic half_s = sync2_q[2];
    wire logic rst_pin_s = sync2_q[3];
    wire logic dis_s = sync2_q[4];
    // Plain edge detect; pulses shorter than one clock period may be missed
    wire logic step_rise = step_s && !step_prev_q;

    // ==========================================
    // Power-on lockout: Home is held until the first undervoltage release
    logic pwr_up_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pwr_up_q <= 1'b1;
        end else if (!undervolt_fault) begin
            pwr_up_q <= 1'b0;
        end
    end
    wire logic home_hold = !rst_pin_s || (pwr_up_q && undervolt_fault);

    // ==========================================
    // Translator
    logic [2:0] idx_q;
    logic decay1_q, decay2_q;
    wire logic [2:0] idx_step = half_s ? 3'h1 : 3'h2;
    wire logic [2:0] idx_new = dir_s ? 3'(idx_q + idx_step) : 3'(idx_q - idx_step);
    wire logic [8:0] p1_old = phase_lvl(idx_q);
    wire logic [8:0] p2_old = phase_lvl(3'(idx_q - 3'h2));
    wire logic [8:0] p1_new = phase_lvl(idx_new);
    wire logic [8:0] p2_new = phase_lvl(3'(idx_new - 3'h2));
    wire logic fall1 = p1_new[7:0] < p1_old[7:0];
    wire logic fall2 = p2_new[7:0] < p2_old[7:0];

    // Step edges keep stepping even while outputs are disabled
    always_ff @(posedge core_clk) begin
        if (sys_rst || home_hold) begin
            idx_q <= HOME_IDX;
            decay1_q <= 1'b1;
            decay2_q <= 1'b1;
        end else if (step_rise) begin
            idx_q <= idx_new;
            decay1_q <= fall1;
            decay2_q <= fall2;
        end
    end

    // ==========================================
    // Level outputs
    // Levels lag the index by one edge so magnitude and sign change together
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            level1 <= LVL_SIN45;
            level2 <= LVL_SIN45;
            pol1_neg <= 1'b0;
            pol2_neg <= 1'b0;
        end else begin
            level1 <= p1_old[7:0];
            level2 <= p2_old[7:0];
            pol1_neg <= p1_old[8];
            pol2_neg <= p2_old[8];
        end
    end

    // ==========================================
    // Off-time selection and bridges
    logic [15:0] osc_units_q;
    wire logic [OFF_CYC_W-1:0] off_res_cyc = OFF_CYC_W'(osc_units_q) * OFF_CYC_W'(CLK_MHZ);
    wire logic [OFF_CYC_W-1:0] off_cyc = off_time_timing_pin ? OFF_CYC_W'(OFF_DEFAULT_CYC) : off_res_cyc;
    wire logic [OFF_CYC_W+2:0] fast_prod = off_cyc * 3'(OFF_FAST_NUM);
    wire logic [OFF_CYC_W-1:0] fast_cyc = OFF_CYC_W'(fast_prod >> OFF_FAST_SHIFT);
    // Fault inputs bypass the synchroniser so a fault cuts the gates at once
    wire logic [3:0] fault_vec = {gate_regulator_monitor, overtemp_fault, undervolt_fault, !rst_pin_s};
    wire logic out_off = dis_s || (|fault_vec);
    wire logic run = !out_off;

    logic [3:0] g1, g2;
    stpdrv_chopper u_bridge1 (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .run(run),
        .polarity_neg(pol1_neg),
        .decay_mixed(decay1_q),
        .cmp_trip(cmp_trip1),
        .off_cycles(off_cyc),
        .fast_cycles(fast_cyc),
        .src_a(g1[3]),
        .src_b(g1[2]),
        .snk_a(g1[1]),
        .snk_b(g1[0]),
        .chopping()
    );
    stpdrv_chopper u_bridge2 (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .run(run),
        .polarity_neg(pol2_neg),
        .decay_mixed(decay2_q),
        .cmp_trip(cmp_trip2),
        .off_cycles(off_cyc),
        .fast_cycles(fast_cyc),
        .src_a(g2[3]),
        .src_b(g2[2]),
        .snk_a(g2[1]),
        .snk_b(g2[0]),
        .chopping()
    );
    // Final gating acts on the chopper outputs so a fault cuts them in one edge
    logic [7:0] gate_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            gate_q <= 8'h00;
        end else begin
            gate_q <= out_off ? 8'h00 : {g1, g2};
        end
    end
    assign {out1a_src, out1b_src, out1a_snk, out1b_snk} = gate_q[7:4];
    assign {out2a_src, out2b_src, out2a_snk, out2b_snk} = gate_q[3:0];

    // ==========================================
    // AHB-Lite slave, zero wait states
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    wire logic addr_ok = hsel && htrans[1] && hready;
    wire logic [7:0] a_ofs = haddr[7:0];
    wire logic [31:0] status_word = {20'h0, fault_vec, out_off, decay2_q, decay1_q, half_s, dir_s, idx_q};
    wire logic [31:0] level_word = {7'h0, pol2_neg, level2, 7'h0, pol1_neg, level1};
    wire logic [31:0] rd_mux = (a_ofs == REG_CFG_OFS) ? {16'h0, osc_units_q} :
                               (a_ofs == REG_STATUS_OFS) ? status_word :
                               (a_ofs == REG_LEVEL_OFS) ? level_word : 32'h0;
    // Read data captured in the address phase, so it stands through the data phase
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata <= 32'h0;
            osc_units_q <= CFG_OSC_UNITS_RST;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_addr_q <= a_ofs;
            end
            if (addr_ok && !hwrite) begin
                hrdata <= rd_mux;
            end
            if (wr_pend_q && wr_addr_q == REG_CFG_OFS) begin
                osc_units_q <= hwdata[15:0];
            end
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ==========================================
    // Checks
    property p_step_adv;
        @(posedge core_clk) disable iff (sys_rst)
        (step_rise && !home_hold) |=> (idx_q == 3'($past(idx_q) + ($past(dir_s) ? 3'h1 : 3'h7) * ($past(half_s) ? 3'h1 : 3'h2)));
    endproperty
    a_step_adv: assert property (p_step_adv) else $error("step did not move index correctly");

    property p_no_step_stable;
        @(posedge core_clk) disable iff (sys_rst)
        (!step_rise && !home_hold) |=> $stable(idx_q);
    endproperty
    a_no_step_stable: assert property (p_no_step_stable) else $error("index moved without step edge");

    property p_reset_home;
        @(posedge core_clk) disable iff (sys_rst)
        !rst_pin_s |=> (idx_q == HOME_IDX && decay1_q && decay2_q) ##1 (gate_q == 8'h00);
    endproperty
    a_reset_home: assert property (p_reset_home) else $error("reset pin did not hold Home with outputs off");

    property p_decay_sel;
        @(posedge core_clk) disable iff (sys_rst)
        (step_rise && !home_hold) |=> (decay1_q == $past(fall1)) && (decay2_q == $past(fall2));
    endproperty
    a_decay_sel: assert property (p_decay_sel) else $error("decay mode not chosen from level change");

    sequence s_out_blocked;
        dis_s || gate_regulator_monitor || overtemp_fault;
    endsequence
    property p_out_off;
        @(posedge core_clk) disable iff (sys_rst)
        s_out_blocked |=> (gate_q == 8'h00);
    endproperty
    a_out_off: assert property (p_out_off) else $error("bridge outputs on while blocked");

    property p_level_track;
        @(posedge core_clk) disable iff (sys_rst)
        step_rise ##1 1'b1 |=> (level1 == $past(p1_old[7:0]) && pol1_neg == $past(p1_old[8])
            && level2 == $past(p2_old[7:0]) && pol2_neg == $past(p2_old[8]));
    endproperty
    a_level_track: assert property (p_level_track) else $error("level output does not follow translator");

    property p_home_levels;
        @(posedge core_clk) disable iff (sys_rst)
        (idx_q == HOME_IDX && $past(idx_q) == HOME_IDX) |=> (level1 == LVL_SIN45 && level2 == LVL_SIN45 && !pol1_neg && !pol2_neg);
    endproperty
    a_home_levels: assert property (p_home_levels) else $error("Home levels wrong");

    property p_pwr_home;
        @(posedge core_clk) disable iff (sys_rst)
        (pwr_up_q && undervolt_fault) |=> (idx_q == HOME_IDX) ##1 (gate_q == 8'h00);
    endproperty
    a_pwr_home: assert property (p_pwr_home) else $error("power-on lockout did not hold Home");

    property p_uv_off;
        @(posedge core_clk) disable iff (sys_rst)
        undervolt_fault |=> (gate_q == 8'h00);
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("bridge outputs on during undervoltage");

endmodule : stpdrv_top
`default_nettype wire

// >>> verification/stpdrv_ctl_model.sv
// Motion controller model: step, direction and step size
`timescale 1ns/1ps
`default_nettype none
module stpdrv_ctl_model (
    input wire logic core_clk,
    output logic step_in,
    output logic dir_in,
    output logic step_size_select
);
    initial begin
        step_in = 1'b0;
        dir_in = 1'b0;
        step_size_select = 1'b1;
    end
    // ====
    // Level inputs, settled well before the next rising step
    task automatic set_in(input logic dir, input logic half);
        @(posedge core_clk);
        dir_in <= dir;
        step_size_select <= half;
        repeat (50) @(posedge core_clk);
    endtask : set_in
    // ====
    // One step pulse, 250 cycles per level
    task automatic pulse();
        @(posedge core_clk);
        step_in <= 1'b1;
        repeat (250) @(posedge core_clk);
        step_in <= 1'b0;
        repeat (250) @(posedge core_clk);
    endtask : pulse
endmodule : stpdrv_ctl_model
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the stepper translator and chopper
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import stpdrv_pkg::*;
    localparam int OFF_CYC = 40;
    localparam logic [7:0] NEG1 = 8'h38;
    localparam logic [7:0] NEG2 = 8'hE0;
    logic core_clk, sys_rst, reset_pin_n, out_disable, tpin, cmp1, cmp2;
    logic step_in, dir_in, ssel, pol1_neg, pol2_neg;
    logic hsel, hwrite, hreadyout, hresp;
    logic [2:0] flt, hsize, idx;
    logic [7:0] level1, level2;
    wire logic [7:0] gates;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [7:0] mag [8] = '{8'hFF, 8'hB4, 8'h00, 8'hB4, 8'hFF, 8'hB4, 8'h00, 8'hB4};
    int n_fail = 0;
    int total_checks = 0;

    stpdrv_ctl_model u_ctl (.core_clk(core_clk), .step_in(step_in), .dir_in(dir_in), .step_size_select(ssel));

    stpdrv_top #(.OFF_DEFAULT_CYC(OFF_CYC)) u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .step_in(step_in), .dir_in(dir_in),
        .step_size_select(ssel), .reset_pin_n(reset_pin_n), .out_disable(out_disable),
        .off_time_timing_pin(tpin), .gate_regulator_monitor(flt[0]), .overtemp_fault(flt[1]),
        .undervolt_fault(flt[2]), .cmp_trip1(cmp1), .cmp_trip2(cmp2), .level1(level1),
        .pol1_neg(pol1_neg), .level2(level2), .pol2_neg(pol2_neg), .out1a_src(gates[7]),
        .out1b_src(gates[6]), .out1a_snk(gates[5]), .out1b_snk(gates[4]), .out2a_src(gates[3]),
        .out2b_src(gates[2]), .out2a_snk(gates[1]), .out2b_snk(gates[0]), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // ====
    // Helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp_val);
        total_checks++;
        if (seen !== exp_val) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", name, exp_val, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // Single AHB-Lite word transfer; read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("hresp", hresp, 1'b0);
    endtask : bus

    task automatic step_chk(input logic dir, input logic half, input logic en);
        logic [2:0] prv;
        prv = idx;
        u_ctl.set_in(dir, half);
        u_ctl.pulse();
        if (en) begin
            idx = dir ? idx + (half ? 3'h1 : 3'h2) : idx - (half ? 3'h1 : 3'h2);
        end
        check("level1", level1, mag[idx]);
        check("level2", level2, mag[idx + 3'h2]);
        if (mag[idx] != 8'h00) check("pol1", pol1_neg, NEG1[idx]);
        if (mag[idx + 3'h2] != 8'h00) check("pol2", pol2_neg, NEG2[idx]);
        bus(1'b0, REG_STATUS_OFS, 32'h0);
        check("index", rd[2:0], idx);
        if (en) check("decay", rd[6:3], {mag[idx + 3'h2] < mag[prv + 3'h2], mag[idx] < mag[prv], half, dir});
    endtask : step_chk

    initial begin
        #(4 * 20000);
        n_fail++;
        stop_test();
    end

    // ====
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        reset_pin_n = 1'b1;
        out_disable = 1'b0;
        tpin = 1'b1;
        cmp1 = 1'b0;
        cmp2 = 1'b0;
        flt = 3'h0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        idx = HOME_IDX;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        bus(1'b0, REG_STATUS_OFS, 32'h0);
        check("home", rd[6:0], {2'h3, 2'h0, HOME_IDX});
        bus(1'b0, REG_LEVEL_OFS, 32'h0);
        check("home_lvl", rd & 32'h01FF_01FF, 32'h00B4_00B4);
        bus(1'b0, REG_CFG_OFS, 32'h0);
        check("cfg_rst", rd[15:0], CFG_OSC_UNITS_RST);
        bus(1'b1, REG_CFG_OFS, 32'h0000_0005);
        bus(1'b1, REG_STATUS_OFS, 32'hFFFF_FFFF);
        bus(1'b0, REG_CFG_OFS, 32'h0);
        check("cfg_wr", rd[15:0], 16'h0005);
        bus(1'b0, 8'h0C, 32'h0);
        check("unmapped", rd, 32'h0);
        $display("registers done");
        // Home is mixed decay: trip gives all-off, then sink only
        repeat (300) @(posedge core_clk);
        check("on", gates[7:4] == 4'h9 || gates[7:4] == 4'h6, 1'b1);
        check("on2", gates[3:0] == 4'h9 || gates[3:0] == 4'h6, 1'b1);
        cmp1 <= 1'b1;
        repeat (8) @(posedge core_clk);
        check("fast", gates[7:4], 4'h0);
        repeat (17) @(posedge core_clk);
        check("slow", {gates[7:6], gates[5] ^ gates[4]}, 3'h1);
        cmp1 <= 1'b0;
        repeat (30) @(posedge core_clk);
        check("reon", gates[7:4] == 4'h9 || gates[7:4] == 4'h6, 1'b1);
        cmp1 <= 1'b1;
        repeat (100) @(posedge core_clk);
        check("blank", gates[7:4] == 4'h9 || gates[7:4] == 4'h6, 1'b1);
        cmp1 <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            flt <= 3'h1 << i;
            repeat (6) @(posedge core_clk);
            check("fault_off", gates, 8'h00);
            flt <= 3'h0;
            repeat (2) @(posedge core_clk);
        end
        $display("chopper done");
        for (int i = 0; i < 8; i++) step_chk(1'b1, 1'b1, 1'b1);
        // Direction change alone must not move the rotor
        u_ctl.set_in(1'b0, 1'b0);
        repeat (300) @(posedge core_clk);
        bus(1'b0, REG_STATUS_OFS, 32'h0);
        check("dir_hold", rd[2:0], idx);
        for (int i = 0; i < 4; i++) step_chk(1'b0, 1'b0, 1'b1);
        // Equal levels leave slow decay; resistor off-time of 5 us holds it
        tpin <= 1'b0;
        cmp1 <= 1'b1;
        repeat (8) @(posedge core_clk);
        check("slow_trip", {gates[7:6], gates[5] ^ gates[4]}, 3'h1);
        cmp1 <= 1'b0;
        repeat (100) @(posedge core_clk);
        check("res_off", {gates[7:6], gates[5] ^ gates[4]}, 3'h1);
        out_disable <= 1'b1;
        step_chk(1'b1, 1'b0, 1'b1);
        check("dis_off", gates, 8'h00);
        out_disable <= 1'b0;
        reset_pin_n <= 1'b0;
        idx = HOME_IDX;
        step_chk(1'b1, 1'b1, 1'b0);
        check("rst_off", gates, 8'h00);
        reset_pin_n <= 1'b1;
        $display("stepping done");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
